// ==== hsp_pkg.sv ====
// Package of constants and types shared by the two-wire target port files.
`default_nettype none
package hsp_pkg;
	// Seven-bit bus address selected by a low address-select pin.
	localparam logic [6:0] ADDR_LOW = 7'h40;
	// Seven-bit bus address selected by a high address-select pin.
	localparam logic [6:0] ADDR_HIGH = 7'h41;
	// Reset value of the register pointer.
	localparam logic [7:0] PTR_RESET = 8'h00;
	// Number of bits in one byte on the wire.
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Master code prefix that announces high rate operation.
	localparam logic [4:0] MCODE_PFX = 5'h01;
	// Transfer phases of the target port.
	typedef enum logic [2:0] {
		HSP_IDLE  = 3'b000,
		HSP_DEVA  = 3'b001,
		HSP_PTR   = 3'b010,
		HSP_WDAT  = 3'b011,
		HSP_RDAT  = 3'b100,
		HSP_MCODE = 3'b101
	} hsp_phase_t;
endpackage : hsp_pkg
`default_nettype wire

// ==== hsp_line_if.sv ====
// Interface carrying filtered bus line events from the sampler to the port.
`default_nettype none
interface hsp_line_if;
	logic scl_rise; // One-cycle pulse on a clock line rising edge.
	logic scl_fall; // One-cycle pulse on a clock line falling edge.
	logic start;    // One-cycle pulse on a START or repeated START.
	logic stop;     // One-cycle pulse on a STOP.
	logic sda;      // Settled data line level.
	modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
	modport dst (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : hsp_line_if
`default_nettype wire

// ==== hsp_line_sync.sv ====
// Three-stage sampler and edge finder for the bus clock and data lines.
`default_nettype none
module hsp_line_sync (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_b,
	// Raw bus lines.
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Line events.
	hsp_line_if.src   ev
);
	logic [2:0] scl_sh_reg; // Clock line shift chain.
	logic [2:0] sda_sh_reg; // Data line shift chain.
	logic       scl_reg;    // Settled clock line level.
	logic       sda_reg;    // Settled data line level.
	wire        scl_agree = (scl_sh_reg[1] == scl_sh_reg[2]);
	wire        sda_agree = (sda_sh_reg[1] == sda_sh_reg[2]);
	wire        scl_next  = scl_agree ? scl_sh_reg[2] : scl_reg;
	wire        sda_next  = sda_agree ? sda_sh_reg[2] : sda_reg;

	// Shift the lines in; a level counts once stages two and three agree.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_sh_reg <= 3'h7;
			sda_sh_reg <= 3'h7;
			scl_reg    <= 1'b1;
			sda_reg    <= 1'b1;
		end
		else
		begin
			scl_sh_reg <= {scl_sh_reg[1:0], scl_in};
			sda_sh_reg <= {sda_sh_reg[1:0], sda_in};
			scl_reg    <= scl_next;
			sda_reg    <= sda_next;
		end
	end

	// Edges and bus conditions derived from the settled levels.
	assign ev.scl_rise = !scl_reg && scl_next;
	assign ev.scl_fall = scl_reg && !scl_next;
	assign ev.start    = scl_reg && scl_next && sda_reg && !sda_next;
	assign ev.stop     = scl_reg && scl_next && !sda_reg && sda_next;
	assign ev.sda      = sda_reg;
endmodule : hsp_line_sync
`default_nettype wire

// ==== hsp_target.sv ====
// Two-wire bus target port with an auto-incrementing register pointer.
`default_nettype none
// How it works
// - Target only; never drives clock, START, STOP.
// - Never holds the clock line low.
// - Data open-drain; clock is input only.
// - Pointer steps after every data byte.
// - Nonexistent pointer address gets not-acknowledge.
// - Transfers continue after invalid pointer.
// - Invalid location reads return zeros.
// - Sequential read runs whole range, wraps.
// - Address pin picks 40h or 41h.
// - Invalid writes discarded, not acknowledged.
// - Unacknowledged master code enters high rate until STOP.
module hsp_target (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Bus pins; clock line is only an input.
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe_b,
	// Address select pin.
	input  wire logic       addr_sel,
	// Register store side.
	input  wire logic [7:0] valid_map_lo,
	input  wire logic [7:0] valid_map_hi,
	input  wire logic [7:0] reg_rdata,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_wr,
	// Mode status.
	output var  logic       high_rate_operation
);
	hsp_line_if ev ();

	// Line sampler feeding the event interface.
	hsp_line_sync u_sync (
		.clk    (clk),
		.rst_b  (rst_b),
		.scl_in (scl_in),
		.sda_in (sda_in),
		.ev     (ev)
	);

	hsp_pkg::hsp_phase_t phase_reg;   // Current transfer phase.
	logic [7:0]          shift_reg;   // Byte shift register.
	logic [3:0]          bit_reg;     // Bits seen in this byte.
	logic                ack_reg;     // In the ninth bit slot.
	logic                ackd_reg;    // Master acknowledged last read byte.
	logic [7:0]          ptr_reg;     // Register pointer.
	logic [6:0]          addr_reg;    // Address from the select pin, sampled every clock.
	logic                hold_reg;    // Pull the data line low.
	logic                wr_reg;      // Write strobe.
	logic [7:0]          wdata_reg;   // Write data.
	logic                hr_reg;      // High rate operation flag.

	// Validity is a window of valid pointer values given by the store side.
	function automatic logic ptr_ok(input logic [7:0] p, input logic [7:0] lo,
		input logic [7:0] hi);
		ptr_ok = (p >= lo) && (p <= hi);
	endfunction : ptr_ok

	wire [7:0] byte_now  = {shift_reg[6:0], ev.sda};
	wire       byte_done = ev.scl_rise && !ack_reg && (bit_reg == hsp_pkg::BYTE_BITS - 4'h1);
	wire       cur_ok    = ptr_ok(ptr_reg, valid_map_lo, valid_map_hi);
	wire [7:0] ptr_inc   = ptr_reg + 8'h01;
	wire [7:0] rd_byte   = cur_ok ? reg_rdata : 8'h00;
	wire [6:0] my_addr   = addr_reg;
	wire       addr_hit  = (byte_now[7:1] == my_addr);

	// Sample the address-select level on every clock after reset release.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			addr_reg <= hsp_pkg::ADDR_LOW;
		else
			addr_reg <= addr_sel ? hsp_pkg::ADDR_HIGH : hsp_pkg::ADDR_LOW;
	end

	// High rate flag: set by an unanswered master code, cleared by STOP.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hr_reg <= 1'b0;
		else if (ev.stop)
			hr_reg <= 1'b0;
		else if (phase_reg == hsp_pkg::HSP_MCODE && ack_reg && ev.scl_rise && ev.sda)
			hr_reg <= 1'b1;
	end

	// Main transfer sequencer; the clock line is only ever observed.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phase_reg <= hsp_pkg::HSP_IDLE;
			shift_reg <= 8'h00;
			bit_reg   <= 4'h0;
			ack_reg   <= 1'b0;
			ackd_reg  <= 1'b0;
			ptr_reg   <= hsp_pkg::PTR_RESET;
			hold_reg  <= 1'b0;
			wr_reg    <= 1'b0;
			wdata_reg <= 8'h00;
		end
		else
		begin
			wr_reg <= 1'b0;
			if (ev.stop)
			begin
				// STOP ends any transfer and releases the line.
				phase_reg <= hsp_pkg::HSP_IDLE;
				hold_reg  <= 1'b0;
				ack_reg   <= 1'b0;
			end
			else if (ev.start)
			begin
				// START or repeated START; master frames every transfer.
				phase_reg <= hsp_pkg::HSP_DEVA;
				bit_reg   <= 4'h0;
				ack_reg   <= 1'b0;
				hold_reg  <= 1'b0;
			end
			else if (phase_reg != hsp_pkg::HSP_IDLE)
			begin
				if (ev.scl_rise && !ack_reg)
				begin
					// Sample one bit, most significant first.
					shift_reg <= byte_now;
					bit_reg   <= bit_reg + 4'h1;
				end
				if (byte_done)
				begin
					unique case (phase_reg)
						hsp_pkg::HSP_DEVA:
						begin
							if (byte_now[7:3] == hsp_pkg::MCODE_PFX)
								phase_reg <= hsp_pkg::HSP_MCODE;
							else if (!addr_hit)
								phase_reg <= hsp_pkg::HSP_IDLE;
						end
						hsp_pkg::HSP_PTR:
							ptr_reg <= byte_now;
						hsp_pkg::HSP_WDAT:
						begin
							// Invalid writes are dropped; the pointer steps anyway.
							wr_reg    <= cur_ok;
							wdata_reg <= byte_now;
						end
						default:
						begin
						end
					endcase
				end
				if (ev.scl_fall && bit_reg == hsp_pkg::BYTE_BITS && !ack_reg)
				begin
					// Enter the acknowledge slot.
					ack_reg <= 1'b1;
					unique case (phase_reg)
						hsp_pkg::HSP_DEVA:  hold_reg <= 1'b1;
						hsp_pkg::HSP_PTR:   hold_reg <= cur_ok;
						hsp_pkg::HSP_WDAT:  hold_reg <= ptr_ok(ptr_reg - 8'h01,
							valid_map_lo, valid_map_hi);
						default:            hold_reg <= 1'b0;
					endcase
					if (phase_reg == hsp_pkg::HSP_WDAT)
						ptr_reg <= ptr_reg;
				end
				else if (ev.scl_rise && ack_reg)
					ackd_reg <= !ev.sda;
				else if (ev.scl_fall && ack_reg)
				begin
					// Leave the acknowledge slot and choose the next phase.
					ack_reg <= 1'b0;
					bit_reg <= 4'h0;
					unique case (phase_reg)
						hsp_pkg::HSP_DEVA:
							phase_reg <= shift_reg[0] ? hsp_pkg::HSP_RDAT : hsp_pkg::HSP_PTR;
						hsp_pkg::HSP_PTR:
							phase_reg <= hsp_pkg::HSP_WDAT;
						hsp_pkg::HSP_RDAT:
							if (!ackd_reg)
								phase_reg <= hsp_pkg::HSP_IDLE;
						hsp_pkg::HSP_MCODE:
							phase_reg <= hsp_pkg::HSP_IDLE;
						default:
						begin
						end
					endcase
					if (phase_reg == hsp_pkg::HSP_RDAT && ackd_reg)
					begin
						// Load the next byte from the stepped, wrapped pointer.
						shift_reg <= rd_byte;
						hold_reg  <= !rd_byte[7];
					end
					else if (phase_reg == hsp_pkg::HSP_DEVA && shift_reg[0])
					begin
						shift_reg <= rd_byte;
						hold_reg  <= !rd_byte[7];
						ackd_reg  <= 1'b1;
					end
					else
						hold_reg <= 1'b0;
				end
				else if (phase_reg == hsp_pkg::HSP_RDAT && !ack_reg && ev.scl_fall)
				begin
					// Drive the next read bit while the clock is low.
					if (bit_reg == hsp_pkg::BYTE_BITS)
						hold_reg <= 1'b0;
					else
						hold_reg <= !shift_reg[7];
				end
				// A sent byte steps the pointer as its last bit ends, whatever the master
				// answers, so the next byte is fetched from the new location in time.
				if (phase_reg == hsp_pkg::HSP_RDAT && ev.scl_fall && !ack_reg &&
					bit_reg == hsp_pkg::BYTE_BITS)
					ptr_reg <= ptr_inc;
				if (phase_reg == hsp_pkg::HSP_WDAT && byte_done)
					ptr_reg <= ptr_inc;
			end
		end
	end

	// Read bits are sampled on the rise, so shift data after each rise.
	// The shift register holds the outgoing byte; bit seven is the next bit.

	// Outputs from flip-flops; line pulled low only, never the clock.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sda_out             <= 1'b1;
			sda_oe_b            <= 1'b1;
			reg_addr            <= hsp_pkg::PTR_RESET;
			reg_wdata           <= 8'h00;
			reg_wr              <= 1'b0;
			high_rate_operation <= 1'b0;
		end
		else
		begin
			sda_out             <= 1'b0;
			sda_oe_b            <= !hold_reg;
			reg_addr            <= (phase_reg == hsp_pkg::HSP_WDAT) ? ptr_reg - 8'h01 : ptr_reg;
			reg_wdata           <= wdata_reg;
			reg_wr              <= wr_reg;
			high_rate_operation <= hr_reg;
		end
	end
endmodule : hsp_target
`default_nettype wire

// ==== hsp_target_checker.sv ====
// Port timing checker for the two-wire target.
`default_nettype none
module hsp_target_checker (
	// Watched ports.
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_b,
	input wire logic [7:0] valid_map_lo,
	input wire logic [7:0] valid_map_hi,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       high_rate_operation
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wa_reg; // Location of the latest write.
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Keeps the latest write location so the pointer step can be judged.
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			wa_reg <= 8'h00;
		else if (reg_wr)
			wa_reg <= reg_addr;
	od_low_a: assert property ($past(rst_b) |-> !sda_out) else $error("data driven high");
	drv_edge_a: assert property ($changed(sda_oe_b) |-> !scl_in) else $error("drive moved");
	drv_hold_a: assert property ($fell(sda_oe_b) |=> (!sda_oe_b) [*8]) else $error("short low");
	rel_hold_a: assert property ($rose(sda_oe_b) |=> sda_oe_b [*8]) else $error("short free");
	wr_valid_a: assert property (reg_wr |-> reg_addr >= valid_map_lo && reg_addr <= valid_map_hi)
		else $error("bad write");
	wr_phase_a: assert property (reg_wr |-> scl_in && sda_oe_b) else $error("write off phase");
	ptr_step_a: assert property (reg_wr |-> ##[1:200] reg_addr == 8'(wa_reg + 8'h01))
		else $error("pointer held");
	hr_exit_a: assert property ($fell(high_rate_operation) |-> scl_in && sda_in)
		else $error("early exit");
endmodule : hsp_target_checker
bind hsp_target hsp_target_checker i_chk (.clk(clk), .rst_b(rst_b), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .valid_map_lo(valid_map_lo),
	.valid_map_hi(valid_map_hi), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.high_rate_operation(high_rate_operation));
`default_nettype wire

// ==== hsp_host.sv ====
// Bus master model that makes the clock, framing and bytes.
`default_nettype none
module hsp_host (
	// System clock and bus data level.
	input  wire logic clk,
	input  wire logic sda,
	// Bus lines; a high data drive releases the line.
	output var  logic scl,
	output var  logic sda_h
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// Waits a number of system clocks.
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask : w
	// One bit of 160 ns: data moves mid-low and is sampled at the end of high.
	task automatic bit_x(input logic v, output logic r);
		sda_h <= v;
		w(4);
		scl <= 1'b1;
		w(8);
		r = sda;
		scl <= 1'b0;
		w(4);
	endtask : bit_x
	// START or repeated START.
	task automatic start();
		sda_h <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(8);
		sda_h <= 1'b0;
		w(8);
		scl <= 1'b0;
		w(4);
	endtask : start
	// STOP, then the bus stays free for a while.
	task automatic stop();
		sda_h <= 1'b0;
		w(4);
		scl <= 1'b1;
		w(8);
		sda_h <= 1'b1;
		w(60);
	endtask : stop
	// Sends a byte MSB first and returns the acknowledge bit.
	task automatic put(input logic [7:0] d, output logic a);
		logic x;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], x);
		bit_x(1'b1, a);
	endtask : put
	// Reads a byte and answers with an acknowledge or a not-acknowledge.
	task automatic get(input logic nack, output logic [7:0] d);
		logic x;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(nack, x);
	endtask : get
endmodule : hsp_host
`default_nettype wire

// ==== tb_hsp_target.sv ====
// Self-checking bench for the two-wire target port.
`default_nettype none
module tb_hsp_target;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, addr_sel, rwr, oe_b, sda_o, hro, scl, sda_h, a;
	logic [7:0] lo, hi, ra, rw, b, p;
	logic [7:0] mem [256];   // Store behind the port.
	logic [7:0] ref_m [256]; // Expected store contents.
	logic [15:0] exp_q [$];  // Expected writes as location and data.
	logic [15:0] e;          // Oldest expected write.
	wire sda;                // Bus data line with pull-up.
	int bad_count, tests_run;
	assign sda = sda_h & (oe_b | sda_o);
	hsp_target i_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
		.sda_oe_b(oe_b), .addr_sel(addr_sel), .valid_map_lo(lo), .valid_map_hi(hi),
		.reg_rdata(mem[ra]), .reg_addr(ra), .reg_wdata(rw), .reg_wr(rwr),
		.high_rate_operation(hro));
	hsp_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
	// Counts and reports one comparison.
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		tests_run++;
		if (g !== x)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	task automatic ack(input logic x);
		chk({7'h00, a}, {7'h00, x});
	endtask : ack
	function automatic logic ok(input logic [7:0] q);
		return q >= lo && q <= hi;
	endfunction : ok
	// Writes one random byte; only valid places are noted as stored.
	task automatic wb(input logic [7:0] q);
		logic [7:0] d;
		d = 8'($urandom);
		if (ok(q))
		begin
			exp_q.push_back({q, d});
			ref_m[q] = d;
		end
		i_host.put(d, a);
		ack(!ok(q));
	endtask : wb
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cuts a hang short.
	initial
	begin
		repeat (30000) @(posedge clk);
		bad_count++;
		$display("MISMATCH %0t timeout", $time);
		test_done();
	end
	// Stores each write and matches it against the oldest note.
	always @(posedge clk)
		if (rwr === 1'b1)
		begin
			mem[ra] <= rw;
			e = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
			chk(ra, e[15:8]);
			chk(rw, e[7:0]);
		end
	initial
	begin
		void'($urandom(63));
		rst_b = 1'b0;
		addr_sel = 1'b0;
		lo = 8'h02;
		hi = 8'hfd;
		foreach (mem[i])
		begin
			mem[i] = 8'($urandom);
			ref_m[i] = mem[i];
		end
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		// Both address pins: foreign address refused, then a write run, across the wrap for the low pin.
		for (int s = 0; s < 2; s++)
		begin
			addr_sel <= s[0];
			p = s ? 8'($urandom % 250 + 2) : 8'hfc;
			i_host.start();
			i_host.put({s ? hsp_pkg::ADDR_LOW : hsp_pkg::ADDR_HIGH, 1'b0}, a);
			ack(1'b1);
			i_host.stop();
			i_host.start();
			i_host.put({s ? hsp_pkg::ADDR_HIGH : hsp_pkg::ADDR_LOW, 1'b0}, a);
			ack(1'b0);
			i_host.put(p, a);
			ack(!ok(p));
			for (int k = 0; k < 7; k++)
				wb(8'(p + k));
			i_host.stop();
		end
		// Invalid pointer, then a read that wraps into valid places.
		i_host.start();
		i_host.put({hsp_pkg::ADDR_HIGH, 1'b0}, a);
		ack(1'b0);
		i_host.put(8'hfe, a);
		ack(1'b1);
		i_host.start();
		i_host.put({hsp_pkg::ADDR_HIGH, 1'b1}, a);
		ack(1'b0);
		for (int k = 0; k < 7; k++)
		begin
			p = 8'(8'hfe + k);
			i_host.get(k == 6, b);
			chk(b, ok(p) ? ref_m[p] : 8'h00);
		end
		i_host.stop();
		// Read from the current pointer: the last, unanswered byte still stepped it.
		i_host.start();
		i_host.put({hsp_pkg::ADDR_HIGH, 1'b1}, a);
		ack(1'b0);
		i_host.get(1'b1, b);
		chk(b, ok(8'h05) ? ref_m[8'h05] : 8'h00);
		i_host.stop();
		// Master code: nobody answers, high rate holds until STOP.
		i_host.start();
		i_host.put({hsp_pkg::MCODE_PFX, 3'h5}, a);
		ack(1'b1);
		repeat (8) @(posedge clk);
		chk({7'h00, hro}, 8'h01);
		i_host.stop();
		chk({7'h00, hro}, 8'h00);
		chk(8'(exp_q.size()), 8'h00);
		test_done();
	end
endmodule : tb_hsp_target
`default_nettype wire
